// [design/tdrs_sequencer.sv]
// Reset sequencer for one duplex transceiver channel whose receive
// clock recovery unit is trained by the transmit PLL output.
// Assumes all inputs synchronous to clock_in (the reference clock,
// also the transmit parallel clock); the receive parallel clock is
// sampled as an ordinary input and its rising edges step the retimer.
`timescale 1ns/1ps
`include "tdrs_cfg.svh"

// Contract
// - PLL power-down resets the whole transceiver, analog and digital
// - Hold tx logic reset and rx power-down until tx PLL lock, then release
// - Rising rx data lock enters settle and loads the countdown
// - Rx logic reset releases only once the countdown reaches zero
// - Lock indications are counter-filtered before any release
// - Any rx data lock toggle reasserts the rx logic reset
// - State is three bits: idle 0, tx wait 1, rx wait 2, settle 3
// - Settle countdown preload is 1000000 counts, for 2 ms
// - Tx request resets transmitter only; rx request resets receiver
// - Rx lock means recovery unit moved from reference to data locking
// - Ref clock is tx parallel clock; rx clock drives rx side; single width
// - Rx lock is sought only after tx lock, since tx PLL trains it
// - Tx logic reset stays high at least four cycles in the tx lock wait; rx reset and requests get no minimum
// - Sync reset in any state restarts at tx lock wait, all asserted
module tdrs_sequencer #(
    parameter logic [`TDRS_TIMER_W-1:0] SETTLE_COUNT = `TDRS_SETTLE_PRELOAD
) (
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    input  wire logic       rx_par_clk_in,
    input  wire logic       sys_async_reset_in,
    input  wire logic       sys_sync_reset_in,
    input  wire logic       tx_rst_req_in,
    input  wire logic       rx_rst_req_in,
    input  wire logic       tx_pll_lock_in,
    input  wire logic       rx_data_lock_in,
    output logic            pll_pd_out,
    output logic            rx_pd_out,
    output logic            tx_rst_out,
    output logic            rx_rst_out,
    output logic [2:0]      state_out,
    output logic            done_out
);

    tdrs_pkg::tdrs_state_type  state_q;
    tdrs_pkg::tdrs_state_type  state_d;
    tdrs_pkg::tdrs_rst_type    rst_q;
    tdrs_pkg::tdrs_rst_type    rst_d;
    logic [`TDRS_TIMER_W-1:0]  timer_q;
    logic [`TDRS_TIMER_W-1:0]  timer_d;
    logic [`TDRS_HOLD_W-1:0]   hold_q;
    logic [`TDRS_HOLD_W-1:0]   hold_d;
    logic [`TDRS_NUM_LOCKS-1:0] lock_raw;
    logic [`TDRS_NUM_LOCKS-1:0] lock_filt;
    logic                      sys_reset;
    logic                      filt_reset;
    logic                      tx_lock_ok;
    logic                      rx_lock_ok;
    logic                      rx_clk_q;
    logic                      rx_clk_d;
    logic                      rx_edge;
    logic                      rx_sync1_q;
    logic                      rx_sync1_d;
    logic                      rx_sync2_q;
    logic                      rx_sync2_d;

    // Both system resets restart the sequence; each one powers down the PLL
    assign sys_reset = sys_async_reset_in | sys_sync_reset_in;

    // Filters restart on any reset so a stale lock is never trusted
    assign filt_reset = reset_in | sys_reset;

    // Lock inputs through glitch filters
    assign lock_raw[`TDRS_LOCK_TX] = tx_pll_lock_in;
    assign lock_raw[`TDRS_LOCK_RX] = rx_data_lock_in;

    // One filter per lock indication
    generate
        for (genvar i = 0; i < `TDRS_NUM_LOCKS; i++) begin : g_filt
            tdrs_lock_filter u_filt (
                .clock_in (clock_in),
                .reset_in (filt_reset),
                .lock_in  (lock_raw[i]),
                .lock_out (lock_filt[i])
            );
        end
    endgenerate

    assign tx_lock_ok = lock_filt[`TDRS_LOCK_TX];
    assign rx_lock_ok = lock_filt[`TDRS_LOCK_RX];

    // Sequencer next state; the wait on tx lock also enforces min hold
    always_comb begin
        state_d = state_q;
        rst_d   = rst_q;
        timer_d = timer_q;
        hold_d  = hold_q;
        if (sys_reset) begin
            state_d = tdrs_pkg::TDRS_WAIT_TX_LOCK;
            rst_d   = '{pll_pd: 1'b1, rx_pd: 1'b1,
                        tx_rst: 1'b1, rx_rst: 1'b1};
            timer_d = SETTLE_COUNT;
            hold_d  = `TDRS_HOLD_ZERO;
        end else begin
            unique case (state_q)
                tdrs_pkg::TDRS_WAIT_TX_LOCK: begin
                    rst_d.pll_pd = 1'b0;
                    if (hold_q != (`TDRS_MIN_RST_CYCLES - `TDRS_HOLD_ONE))
                        hold_d = hold_q + `TDRS_HOLD_ONE;
                    if (tx_lock_ok && hold_q ==
                        (`TDRS_MIN_RST_CYCLES - `TDRS_HOLD_ONE)) begin
                        state_d      = tdrs_pkg::TDRS_WAIT_RX_LOCK;
                        rst_d.tx_rst = 1'b0;
                        rst_d.rx_pd  = 1'b0;
                    end else begin
                        rst_d.tx_rst = 1'b1;
                        rst_d.rx_pd  = 1'b1;
                    end
                    rst_d.rx_rst = 1'b1;
                end
                tdrs_pkg::TDRS_WAIT_RX_LOCK: begin
                    rst_d.rx_rst = 1'b1;
                    rst_d.tx_rst = tx_rst_req_in;
                    if (rx_lock_ok) begin
                        state_d = tdrs_pkg::TDRS_SETTLE;
                        timer_d = SETTLE_COUNT;
                    end
                end
                tdrs_pkg::TDRS_SETTLE: begin
                    rst_d.tx_rst = tx_rst_req_in;
                    if (!rx_lock_ok) begin
                        // Lock dropped during settle: start the wait over
                        state_d = tdrs_pkg::TDRS_WAIT_RX_LOCK;
                    end else if (timer_q == `TDRS_TIMER_ZERO) begin
                        state_d      = tdrs_pkg::TDRS_IDLE;
                        rst_d.rx_rst = rx_rst_req_in;
                    end else begin
                        timer_d = timer_q - `TDRS_TIMER_ONE;
                    end
                end
                tdrs_pkg::TDRS_IDLE: begin
                    rst_d.tx_rst = tx_rst_req_in;
                    rst_d.rx_rst = rx_rst_req_in;
                    if (!rx_lock_ok) begin
                        // Receiver lost data lock: reset its logic again
                        state_d      = tdrs_pkg::TDRS_WAIT_RX_LOCK;
                        rst_d.rx_rst = 1'b1;
                    end
                end
                default: begin
                    state_d = tdrs_pkg::TDRS_WAIT_TX_LOCK;
                    rst_d   = '{pll_pd: 1'b1, rx_pd: 1'b1,
                                tx_rst: 1'b1, rx_rst: 1'b1};
                    hold_d  = `TDRS_HOLD_ZERO;
                end
            endcase
        end
    end

    // Sequencer registers; block reset behaves like a system reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q <= tdrs_pkg::TDRS_WAIT_TX_LOCK;
            rst_q   <= '{pll_pd: 1'b1, rx_pd: 1'b1,
                         tx_rst: 1'b1, rx_rst: 1'b1};
            timer_q <= `TDRS_SETTLE_PRELOAD;
            hold_q  <= `TDRS_HOLD_ZERO;
        end else begin
            state_q <= state_d;
            rst_q   <= rst_d;
            timer_q <= timer_d;
            hold_q  <= hold_d;
        end
    end

    // Receive retimer: two stages stepped by rx parallel clock edges.
    // Sampling that clock limits it to below half the reference rate.
    always_comb begin
        rx_clk_d   = rx_par_clk_in;
        rx_edge    = rx_par_clk_in & ~rx_clk_q;
        rx_sync1_d = rx_edge ? rst_q.rx_rst : rx_sync1_q;
        rx_sync2_d = rx_edge ? rx_sync1_q : rx_sync2_q;
        if (sys_reset) begin
            rx_sync1_d = 1'b1;
            rx_sync2_d = 1'b1;
        end
    end

    // Retimer registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_clk_q   <= 1'b1; // No false edge right after release
            rx_sync1_q <= 1'b1;
            rx_sync2_q <= 1'b1;
        end else begin
            rx_clk_q   <= rx_clk_d;
            rx_sync1_q <= rx_sync1_d;
            rx_sync2_q <= rx_sync2_d;
        end
    end

    // Outputs from flops, done_out decoded from the state flops; single width datapath assumed
    assign pll_pd_out = rst_q.pll_pd;
    assign rx_pd_out  = rst_q.rx_pd;
    assign tx_rst_out = rst_q.tx_rst;
    assign rx_rst_out = rx_sync2_q;
    assign state_out  = state_q;
    assign done_out   = (state_q == tdrs_pkg::TDRS_IDLE);

    AST_PD_ALL: assert property (@(posedge clock_in) disable iff (reset_in)
        rst_q.pll_pd |-> rst_q.rx_pd && rst_q.tx_rst && rst_q.rx_rst)
        else $error("power-down without all resets");

    AST_SYS_RST: assert property (@(posedge clock_in) disable iff (reset_in)
        sys_reset |=> (state_q == tdrs_pkg::TDRS_WAIT_TX_LOCK
            && rst_q == 4'hF) ##1 (!rst_q.pll_pd || $past(sys_reset)))
        else $error("system reset not applied");

    AST_TX_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
        state_q == tdrs_pkg::TDRS_WAIT_TX_LOCK && !tx_lock_ok
        |=> rst_q.tx_rst && rst_q.rx_pd)
        else $error("tx reset released without lock");

    AST_SETTLE_LOAD: assert property (@(posedge clock_in)
        disable iff (reset_in)
        state_q == tdrs_pkg::TDRS_WAIT_RX_LOCK && rx_lock_ok && !sys_reset
        |=> state_q == tdrs_pkg::TDRS_SETTLE && timer_q == SETTLE_COUNT)
        else $error("settle not entered with preload");

    AST_RX_RELEASE: assert property (@(posedge clock_in)
        disable iff (reset_in)
        $fell(rst_q.rx_rst) && $past(state_q) != tdrs_pkg::TDRS_IDLE
        |-> $past(state_q) == tdrs_pkg::TDRS_SETTLE
            && $past(timer_q) == `TDRS_TIMER_ZERO)
        else $error("rx reset released before countdown");

    AST_FILTER: assert property (@(posedge clock_in) disable iff (reset_in)
        $rose(rx_lock_ok) |-> $past(rx_data_lock_in, 1)
            && $past(rx_data_lock_in, 2) && $past(rx_data_lock_in, 3)
            && $past(rx_data_lock_in, 8))
        else $error("unfiltered lock passed");

    AST_LOCK_LOSS: assert property (@(posedge clock_in)
        disable iff (reset_in)
        (state_q == tdrs_pkg::TDRS_IDLE || state_q == tdrs_pkg::TDRS_SETTLE)
        && !rx_lock_ok |=> rst_q.rx_rst ##1 state_q != tdrs_pkg::TDRS_IDLE)
        else $error("lock loss did not reset receiver");

    AST_TX_MIN: assert property (@(posedge clock_in) disable iff (reset_in)
        $fell(rst_q.tx_rst) && $past(state_q) ==
            tdrs_pkg::TDRS_WAIT_TX_LOCK
        |-> $past(rst_q.tx_rst, 4))
        else $error("tx reset shorter than four cycles");

    AST_RX_ORDER: assert property (@(posedge clock_in)
        disable iff (reset_in)
        state_q == tdrs_pkg::TDRS_WAIT_RX_LOCK |-> !rst_q.pll_pd
            && !rst_q.rx_pd)
        else $error("rx lock sought before tx lock");

    AST_SYNC_PATH: assert property (@(posedge clock_in)
        disable iff (reset_in)
        !sys_reset && rx_edge && rx_sync1_q != rx_sync2_q
        |=> rx_sync2_q == $past(rx_sync1_q))
        else $error("retimer stage skipped");

endmodule : tdrs_sequencer

// [inc/tdrs_cfg.svh]
// Constants for the duplex transceiver reset sequencer.
// Assumes inclusion by bare name from design files under design/.
`ifndef TDRS_CFG_SVH
`define TDRS_CFG_SVH

// Settle countdown preload, sized for 2 ms at the fastest line rate
`define TDRS_SETTLE_TIME_MS  2
`define TDRS_SETTLE_PRELOAD  20'hF4240
`define TDRS_TIMER_W         20
`define TDRS_TIMER_ZERO      20'h00000
`define TDRS_TIMER_ONE       20'h00001

// Least hold of a logic reset, in parallel clock cycles
`define TDRS_MIN_RST_CYCLES  3'h4
`define TDRS_HOLD_W          3
`define TDRS_HOLD_ZERO       3'h0
`define TDRS_HOLD_ONE        3'h1

// Lock filter: cycles a lock must stay high before it is trusted
`define TDRS_LOCK_FILT       4'h8
`define TDRS_FILT_W          4
`define TDRS_FILT_ZERO       4'h0
`define TDRS_FILT_ONE        4'h1

// Lock filter indices
`define TDRS_LOCK_TX         0
`define TDRS_LOCK_RX         1
`define TDRS_NUM_LOCKS       2

`endif

// [inc/tdrs_pkg.sv]
// Types for the duplex transceiver reset sequencer.
// Assumes the configuration header is compiled alongside.
package tdrs_pkg;

    // Sequencer states, three-bit encoding fixed by the hard block flow
    typedef enum logic [2:0] {
        TDRS_IDLE         = 3'h0,
        TDRS_WAIT_TX_LOCK = 3'h1,
        TDRS_WAIT_RX_LOCK = 3'h2,
        TDRS_SETTLE       = 3'h3
    } tdrs_state_type;

    // Reset lines that travel together to the transceiver
    typedef struct packed {
        logic pll_pd;
        logic rx_pd;
        logic tx_rst;
        logic rx_rst;
    } tdrs_rst_type;

endpackage : tdrs_pkg

// [design/tdrs_lock_filter.sv]
// Lock glitch filter: output rises only after the input stays high
// for a full count, and drops in the cycle after the input drops.
// Assumes the lock input is already synchronous to clock_in.
`timescale 1ns/1ps
`include "tdrs_cfg.svh"

module tdrs_lock_filter (
    input  wire logic clock_in,
    input  wire logic reset_in,
    input  wire logic lock_in,
    output logic      lock_out
);

    logic [`TDRS_FILT_W-1:0] count_q;
    logic [`TDRS_FILT_W-1:0] count_d;
    logic                    stable_q;
    logic                    stable_d;

    // Count consecutive high samples; any low sample restarts
    always_comb begin
        count_d  = count_q;
        stable_d = stable_q;
        if (!lock_in) begin
            count_d  = `TDRS_FILT_ZERO;
            stable_d = 1'b0;
        end else if (count_q == (`TDRS_LOCK_FILT - `TDRS_FILT_ONE)) begin
            stable_d = 1'b1;
        end else begin
            count_d = count_q + `TDRS_FILT_ONE;
        end
    end

    // Register stage
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count_q  <= `TDRS_FILT_ZERO;
            stable_q <= 1'b0;
        end else begin
            count_q  <= count_d;
            stable_q <= stable_d;
        end
    end

    assign lock_out = stable_q;

endmodule : tdrs_lock_filter

// [tb/tdrs_xcvr_model.sv]
// Behavioural transceiver hard block: lock outputs and rx clock.
// Assumes it is driven by the sequencer resets and the bench enables.
`timescale 1ns/1ps

module tdrs_xcvr_model #(
    parameter int TX_DELAY = 6,
    parameter int RX_DELAY = 10
) (
    input  wire logic clock_in,
    input  wire logic pll_pd_in,
    input  wire logic rx_pd_in,
    input  wire logic tx_en_in,
    input  wire logic rx_en_in,
    output logic      tx_lock_out,
    output logic      rx_lock_out,
    output logic      rx_clk_out
);
    int         tx_cnt = 0;
    int         rx_cnt = 0;
    logic [1:0] div_q  = 2'h0;

    // Power-down clears all training at once
    // Rx trains only on a locked tx PLL
    always @(negedge clock_in) begin
        tx_cnt <= pll_pd_in ? 0 : tx_cnt + 1;
        rx_cnt <= (rx_pd_in || !rx_en_in || !tx_lock_out) ? 0 : rx_cnt + 1;
        div_q  <= div_q + 2'h1;
    end

    // Enables let the bench chop a lock into glitches
    assign tx_lock_out = tx_en_in && !pll_pd_in && tx_cnt >= TX_DELAY;
    assign rx_lock_out = rx_en_in && tx_lock_out && rx_cnt >= RX_DELAY;
    // Quarter-rate rx parallel clock, below half the reference
    assign rx_clk_out  = div_q[1];
endmodule : tdrs_xcvr_model

// [tb/transceiver_duplex_reset_sequencer_tb_top.sv]
// Self-checking bench for the duplex transceiver reset sequencer.
// Assumes the design files and the transceiver model are compiled first.
`timescale 1ns/1ps

module transceiver_duplex_reset_sequencer_tb_top;
    localparam logic [19:0] SC = 20'h00014;
    logic       clock_in = 1'b0;
    logic       reset_in = 1'b1;
    logic       async_rst = 1'b0;
    logic       sync_rst = 1'b0;
    logic       tx_req = 1'b0;
    logic       rx_req = 1'b0;
    logic       tx_en = 1'b0;
    logic       rx_en = 1'b0;
    logic       tx_lock, rx_lock, rx_clk;
    logic       pll_pd, rx_pd, tx_rst, rx_rst, done;
    logic [2:0] state, last_st;
    logic [2:0] exp_q[$];
    int         mismatches = 0;
    int         checks = 0;
    int         cycles = 0;
    int         seed = 33;
    int         n, k;

    tdrs_sequencer #(.SETTLE_COUNT(SC)) uut (
        .clock_in(clock_in), .reset_in(reset_in), .rx_par_clk_in(rx_clk),
        .sys_async_reset_in(async_rst), .sys_sync_reset_in(sync_rst),
        .tx_rst_req_in(tx_req), .rx_rst_req_in(rx_req),
        .tx_pll_lock_in(tx_lock), .rx_data_lock_in(rx_lock),
        .pll_pd_out(pll_pd), .rx_pd_out(rx_pd), .tx_rst_out(tx_rst),
        .rx_rst_out(rx_rst), .state_out(state), .done_out(done));

    tdrs_xcvr_model xcvr (
        .clock_in(clock_in), .pll_pd_in(pll_pd), .rx_pd_in(rx_pd),
        .tx_en_in(tx_en), .rx_en_in(rx_en), .tx_lock_out(tx_lock),
        .rx_lock_out(rx_lock), .rx_clk_out(rx_clk));

    // 125 MHz reference clock
    initial begin
        forever #4 clock_in = ~clock_in;
    end

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic chk_state(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_state

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic cyc(input int c);
        repeat (c) @(negedge clock_in);
    endtask : cyc

    // Bounded wait for a state, returning cycles spent
    task automatic wait_st(input logic [2:0] s, output int c);
        c = 0;
        while (state !== s && c < 300) begin
            c++;
            cyc(1);
        end
        chk_state(state, s);
    endtask : wait_st

    // Reference trace: every state change pops the next expected step;
    // a cycle ceiling cuts a hang short
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
        #1;
        if (!reset_in && state !== last_st) begin
            if (exp_q.size() == 0) chk_state(state, 3'h7);
            else chk_state(state, exp_q.pop_front());
        end
        last_st = state;
    end

    initial begin
        cyc(12);
        chk_bit(pll_pd, 1'b1);
        chk_bit(tx_rst, 1'b1);
        reset_in = 1'b0;
        // Short random tx lock glitches must not release anything
        for (k = 0; k < 3; k++) begin
            cyc(10);
            tx_en = 1'b1;
            cyc(1 + ($unsigned($random(seed)) % 7));
            tx_en = 1'b0;
        end
        cyc(4);
        chk_state(state, 3'h1);
        chk_bit(tx_rst, 1'b1);
        chk_bit(rx_pd, 1'b1);
        $display("test glitch done");
        // Full sequence with settle count measured
        exp_q = '{3'h2, 3'h3, 3'h0};
        tx_en = 1'b1;
        rx_en = 1'b1;
        wait_st(3'h2, n);
        chk_bit(tx_rst, 1'b0);
        chk_bit(rx_rst, 1'b1);
        wait_st(3'h3, n);
        n = 0;
        while (state === 3'h3 && n < 100) begin
            n++;
            cyc(1);
        end
        chk_cnt(n, int'(SC) + 1);
        chk_bit(rx_rst, 1'b1);
        cyc(12);
        chk_bit(rx_rst, 1'b0);
        chk_bit(done, 1'b1);
        $display("test sequence done");
        // Rx lock toggle in idle resets the receiver again
        exp_q = '{3'h2, 3'h3, 3'h0};
        rx_en = 1'b0;
        cyc(12);
        chk_bit(rx_rst, 1'b1);
        chk_bit(tx_rst, 1'b0);
        rx_en = 1'b1;
        wait_st(3'h0, n);
        cyc(12);
        // User requests held four cycles and more, each side alone
        tx_req = 1'b1;
        cyc(4);
        chk_bit(tx_rst, 1'b1);
        chk_bit(rx_rst, 1'b0);
        tx_req = 1'b0;
        rx_req = 1'b1;
        cyc(12);
        chk_bit(rx_rst, 1'b1);
        chk_bit(tx_rst, 1'b0);
        rx_req = 1'b0;
        cyc(12);
        chk_bit(rx_rst, 1'b0);
        $display("test requests done");
        // Sync reset in idle, then async reset in settle
        for (k = 0; k < 2; k++) begin
            if (k == 1) begin
                exp_q = '{3'h2, 3'h3, 3'h2, 3'h3};
                rx_en = 1'b0;
                cyc(2);
                rx_en = 1'b1;
                wait_st(3'h3, n);
                // Lock lost in settle sends it back to the rx wait
                rx_en = 1'b0;
                cyc(2);
                chk_state(state, 3'h2);
                chk_bit(rx_rst, 1'b1);
                rx_en = 1'b1;
                wait_st(3'h3, n);
            end
            exp_q.push_back(3'h1);
            exp_q.push_back(3'h2);
            exp_q.push_back(3'h3);
            exp_q.push_back(3'h0);
            if (k == 1) async_rst = 1'b1;
            else sync_rst = 1'b1;
            cyc(1);
            chk_state(state, 3'h1);
            chk_bit(pll_pd, 1'b1);
            chk_bit(rx_pd, 1'b1);
            chk_bit(tx_rst, 1'b1);
            chk_bit(rx_rst, 1'b1);
            chk_bit(done, 1'b0);
            async_rst = 1'b0;
            sync_rst = 1'b0;
            cyc(1);
            chk_bit(pll_pd, 1'b0);
            chk_bit(tx_rst, 1'b1);
            wait_st(3'h2, n);
            chk_cnt(int'(n >= 3), 1);
            wait_st(3'h0, n);
            cyc(12);
            $display("test system reset %0d done", k);
        end
        give_verdict();
    end
endmodule : transceiver_duplex_reset_sequencer_tb_top
